/* gis_defs.svh */
// Purpose: offsets, field positions, reset values and bus command codes
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   included by the command decoder, the status word block and the test
`ifndef GIS_DEFS_SVH
`define GIS_DEFS_SVH

// Register byte offsets
`define GIS_OFF_STATUS   12'h000
`define GIS_OFF_ERRCODE  12'h004
`define GIS_OFF_COUNT    12'h008
`define GIS_OFF_CTRL     12'h00c
`define GIS_OFF_CALL     12'h010
`define GIS_OFF_ADDR     12'h014

// Status word bit positions
`define GIS_BIT_ERR      15
`define GIS_BIT_TIMEOUT_FLAG     14
`define GIS_BIT_END      13
`define GIS_BIT_SRQ      12
`define GIS_BIT_COMPLETION_FLAG     8
`define GIS_BIT_LOK      7
`define GIS_BIT_REM      6
`define GIS_BIT_CIC      5
`define GIS_BIT_ATN      4
`define GIS_BIT_TACS     3
`define GIS_BIT_LACS     2
`define GIS_BIT_DTAS     1
`define GIS_BIT_DCAS     0

// Control register fields
`define GIS_CTRL_EOS_EN  0
`define GIS_CTRL_EOI_ONLY 1
`define GIS_CTRL_SEC_EN  2
`define GIS_CTRL_EOS_LSB 8

// Call register fields
`define GIS_CALL_ERR     15
`define GIS_CALL_TIMEOUT_FLAG    14
`define GIS_CALL_IO      13
`define GIS_CALL_DTAS_CLR 1
`define GIS_CALL_DCAS_CLR 0
`define GIS_CALL_CODE_LSB 16

// Reset values
`define GIS_RST_STATUS   16'h0100
`define GIS_RST_CTRL     16'h0000
`define GIS_RST_ADDR     16'h0000

// Bus command bytes (ATN true)
`define GIS_CMD_GTL      8'h01
`define GIS_CMD_SDC      8'h04
`define GIS_CMD_GET      8'h08
`define GIS_CMD_LLO      8'h11
`define GIS_CMD_DCL      8'h14
`define GIS_CMD_UNL      8'h3f
`define GIS_CMD_UNT      8'h5f

`endif

/* gis_pkg.sv */
// Purpose: shared types for the interface status word block
// Assumes: constants come from gis_defs.svh
// Notes:   types only
package gis_pkg;
	typedef logic [15:0] gis_word_t;
	typedef enum logic [1:0] {
		GIS_IDLE  = 2'b00,
		GIS_XFER  = 2'b01,
		GIS_DONE  = 2'b10
	} gis_xfer_e;
endpackage

/* gis_cmd_decode.sv */
// Purpose: decodes one bus command byte seen with attention true
// Assumes: address bytes use the usual 0x20 listen / 0x40 talk groups
// Notes:   purely combinational
`timescale 1ns/1ps
`include "gis_defs.svh"
module gis_cmd_decode (
	input  wire logic [7:0] cmd_byte,
	input  wire logic [4:0] own_addr,
	output logic            is_my_listen,
	output logic            is_my_talk,
	output logic            is_other_talk,
	output logic            is_unl,
	output logic            is_unt,
	output logic            is_llo,
	output logic            is_gtl,
	output logic            is_get,
	output logic            is_dcl,
	output logic            is_sdc,
	output logic            is_secondary
);
	wire [6:0] code = cmd_byte[6:0];

	// Address groups and universal or addressed commands
	assign is_unl        = code == 7'(`GIS_CMD_UNL);
	assign is_unt        = code == 7'(`GIS_CMD_UNT);
	assign is_my_listen  = code[6:5] == 2'h1 && !is_unl
		&& code[4:0] == own_addr;
	assign is_my_talk    = code[6:5] == 2'h2 && !is_unt
		&& code[4:0] == own_addr;
	assign is_other_talk = code[6:5] == 2'h2 && !is_unt
		&& code[4:0] != own_addr;
	assign is_llo        = code == 7'(`GIS_CMD_LLO);
	assign is_gtl        = code == 7'(`GIS_CMD_GTL);
	assign is_get        = code == 7'(`GIS_CMD_GET);
	assign is_dcl        = code == 7'(`GIS_CMD_DCL);
	assign is_sdc        = code == 7'(`GIS_CMD_SDC);
	assign is_secondary  = code[6:5] == 2'h3 && code != 7'h7f;
endmodule

/* gis_xfer_counter.sv */
// Purpose: unsigned byte counter for one transfer
// Assumes: start clears, each byte strobe adds one
// Notes:   wraps past its width
`timescale 1ns/1ps
module gis_xfer_counter #(
	parameter int WIDTH = 32
) (
	input  wire logic             core_clk,
	input  wire logic             reset_n,
	input  wire logic             start,
	input  wire logic             byte_stb,
	output logic      [WIDTH-1:0] count
);
	// Clear on start, then count bytes
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			count <= '0;
		else if (start)
			count <= '0;
		else if (byte_stb)
			count <= count + WIDTH'(1);
	end
endmodule

/* gis_status_word.sv */
// Purpose: interface status word, error code and byte count over APB
// Assumes: bus event inputs are synchronous one-cycle strobes
// Notes:   call end is a write to the call register
`timescale 1ns/1ps
`include "gis_defs.svh"

// Operation
// - Keep a sixteen-bit status word, refreshed at every rising clock edge.
// - After each call, expose status, error code and byte count.
// - Some flags apply to all calls, others only board-level.
// - Bit 15 error flag set on failing call, cleared on clean call.
// - Error code only meaningful while the error flag is set.
// - Bit 14 timeout on wait or transfer time-out, else cleared.
// - Bit 13 end on EOI or enabled EOS byte, cleared at transfer start.
// - With EOI-only option, end flag set on EOI alone.
// - Bit 12 follows controller-in-charge AND service request line.
// - Bit 8 completion set when transfer done, clear while in progress.
// - Bit 7 lockout set on Local Lockout, cleared when REN drops.
// - Bit 6 remote set by REN plus own listen address.
// - Remote cleared on REN drop or Go To Local while listener.
// - Bits 5 to 0 hold controller, attention, talk, listen, trigger, clear.
// - Byte count is unsigned, up to a 4 GB range.
// - Controller flag set on take or receive control, cleared IFC or pass.
// - Attention flag follows the ATN line.
// - Talker set on own talk address, cleared UNT, own listen, other talk, IFC.
// - Listener set on own listen address, cleared UNL, own talk, IFC.
module gis_status_word
	import gis_pkg::*;
#(
	parameter int CNT_W = 32
) (
	input  wire logic              core_clk,
	input  wire logic              reset_n,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              atn_line,
	input  wire logic              srq_line,
	input  wire logic              ren_line,
	input  wire logic              ifc_line,
	input  wire logic              cmd_stb,
	input  wire logic [7:0]        cmd_data,
	input  wire logic              xfer_start,
	input  wire logic              byte_stb,
	input  wire logic [7:0]        byte_data,
	input  wire logic              byte_eoi,
	input  wire logic              xfer_done,
	input  wire logic              ctrl_take,
	input  wire logic              ctrl_pass,
	output gis_pkg::gis_word_t     status_word,
	output logic      [15:0]       error_code,
	output logic      [CNT_W-1:0]  xfer_count,
	output logic                   eoi_only_mode
);
	import gis_pkg::*;

	// APB decode
	wire acc    = psel && penable;
	wire wr     = acc && pwrite;
	wire hit_st = paddr == `GIS_OFF_STATUS;
	wire hit_ec = paddr == `GIS_OFF_ERRCODE;
	wire hit_ct = paddr == `GIS_OFF_COUNT;
	wire hit_cr = paddr == `GIS_OFF_CTRL;
	wire hit_cl = paddr == `GIS_OFF_CALL;
	wire hit_ad = paddr == `GIS_OFF_ADDR;
	wire mapped = hit_st || hit_ec || hit_ct || hit_cr || hit_cl || hit_ad;
	wire call_wr = wr && hit_cl;
	assign pready  = 1'b1;
	assign pslverr = acc && !mapped;

	// Control and address registers
	logic [15:0] ctrl_reg;
	logic [15:0] addr_reg;
	logic [15:0] errc_reg;
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_reg <= `GIS_RST_CTRL;
			addr_reg <= `GIS_RST_ADDR;
		end else begin
			if (wr && hit_cr)
				ctrl_reg <= pwdata[15:0];
			if (wr && hit_ad)
				addr_reg <= pwdata[15:0];
		end
	end
	wire       eos_en   = ctrl_reg[`GIS_CTRL_EOS_EN];
	wire       eoi_only = ctrl_reg[`GIS_CTRL_EOI_ONLY];
	wire       sec_en   = ctrl_reg[`GIS_CTRL_SEC_EN];
	wire [7:0] eos_char = ctrl_reg[`GIS_CTRL_EOS_LSB +: 8];
	assign eoi_only_mode = eoi_only;

	// Command byte decode
	logic my_lsn, my_tlk, oth_tlk, unl, unt, llo, gtl, get, dcl, sdc, sec;
	gis_cmd_decode u_dec (
		.cmd_byte      (cmd_data),
		.own_addr      (addr_reg[4:0]),
		.is_my_listen  (my_lsn),
		.is_my_talk    (my_tlk),
		.is_other_talk (oth_tlk),
		.is_unl        (unl),
		.is_unt        (unt),
		.is_llo        (llo),
		.is_gtl        (gtl),
		.is_get        (get),
		.is_dcl        (dcl),
		.is_sdc        (sdc),
		.is_secondary  (sec)
	);
	wire cs = cmd_stb && atn_line;
	wire sec_ok = sec && cmd_data[4:0] == addr_reg[12:8];

	// Pending primary address when secondary addressing is enabled
	logic pend_lsn_reg;
	logic pend_tlk_reg;
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			pend_lsn_reg <= 1'b0;
			pend_tlk_reg <= 1'b0;
		end else if (cs) begin
			pend_lsn_reg <= sec_en && my_lsn;
			pend_tlk_reg <= sec_en && my_tlk;
		end
	end
	wire lsn_hit = cs && (sec_en ? pend_lsn_reg && sec_ok : my_lsn);
	wire tlk_hit = cs && (sec_en ? pend_tlk_reg && sec_ok : my_tlk);

	// Transfer counter
	gis_xfer_counter #(.WIDTH(CNT_W)) u_cnt (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.start    (xfer_start),
		.byte_stb (byte_stb),
		.count    (xfer_count)
	);

	// Transfer state
	gis_xfer_e xs_reg;
	gis_xfer_e xs_next;
	always_comb begin
		xs_next = xs_reg;
		case (xs_reg)
			GIS_IDLE: begin
				if (xfer_start)
					xs_next = GIS_XFER;
			end
			GIS_XFER: begin
				if (xfer_done)
					xs_next = GIS_DONE;
			end
			GIS_DONE: begin
				if (xfer_start)
					xs_next = GIS_XFER;
			end
			default: xs_next = GIS_IDLE;
		endcase
	end

	// Live bus state flags
	logic cic_reg, tacs_reg, lacs_reg, lok_reg, rem_reg;
	logic end_reg, dtas_reg, dcas_reg;
	wire eos_hit = byte_stb && eos_en && byte_data == eos_char;
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			xs_reg   <= GIS_IDLE;
			cic_reg  <= 1'b0;
			tacs_reg <= 1'b0;
			lacs_reg <= 1'b0;
			lok_reg  <= 1'b0;
			rem_reg  <= 1'b0;
			end_reg  <= 1'b0;
			dtas_reg <= 1'b0;
			dcas_reg <= 1'b0;
		end else begin
			xs_reg <= xs_next;
			if (ctrl_take)
				cic_reg <= 1'b1;
			else if (ifc_line || ctrl_pass)
				cic_reg <= 1'b0;
			if (tlk_hit)
				tacs_reg <= 1'b1;
			else if (ifc_line || (cs && (unt || my_lsn || oth_tlk)))
				tacs_reg <= 1'b0;
			if (lsn_hit)
				lacs_reg <= 1'b1;
			else if (ifc_line || (cs && (unl || my_tlk)))
				lacs_reg <= 1'b0;
			if (!ren_line)
				lok_reg <= 1'b0;
			else if (cs && llo)
				lok_reg <= 1'b1;
			if (!ren_line || (cs && gtl && lacs_reg))
				rem_reg <= 1'b0;
			else if (lsn_hit)
				rem_reg <= 1'b1;
			if (byte_stb && (byte_eoi || (!eoi_only && eos_hit)))
				end_reg <= 1'b1;
			else if (xfer_start)
				end_reg <= 1'b0;
			if (cs && get && lacs_reg)
				dtas_reg <= 1'b1;
			else if (call_wr && pwdata[`GIS_CALL_DTAS_CLR])
				dtas_reg <= 1'b0;
			if (cs && (dcl || (sdc && lacs_reg)))
				dcas_reg <= 1'b1;
			else if (call_wr && (pwdata[`GIS_CALL_DCAS_CLR]
				|| pwdata[`GIS_CALL_IO]))
				dcas_reg <= 1'b0;
		end
	end

	// Call-end latched error, timeout and error code
	logic err_reg, timeout_flag_reg;
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			err_reg  <= 1'b0;
			timeout_flag_reg <= 1'b0;
			errc_reg <= 16'h0000;
		end else if (call_wr) begin
			err_reg  <= pwdata[`GIS_CALL_ERR];
			timeout_flag_reg <= pwdata[`GIS_CALL_TIMEOUT_FLAG];
			if (pwdata[`GIS_CALL_ERR])
				errc_reg <= pwdata[`GIS_CALL_CODE_LSB +: 16];
		end
	end
	assign error_code = err_reg ? errc_reg : 16'h0000;

	// Status word assembly
	gis_word_t sw;
	always_comb begin
		sw = 16'h0000;
		sw[`GIS_BIT_ERR]  = err_reg;
		sw[`GIS_BIT_TIMEOUT_FLAG] = timeout_flag_reg;
		sw[`GIS_BIT_END]  = end_reg;
		sw[`GIS_BIT_SRQ]  = cic_reg && srq_line;
		sw[`GIS_BIT_COMPLETION_FLAG] = xs_reg != GIS_XFER;
		sw[`GIS_BIT_LOK]  = lok_reg;
		sw[`GIS_BIT_REM]  = rem_reg;
		sw[`GIS_BIT_CIC]  = cic_reg;
		sw[`GIS_BIT_ATN]  = atn_line;
		sw[`GIS_BIT_TACS] = tacs_reg;
		sw[`GIS_BIT_LACS] = lacs_reg;
		sw[`GIS_BIT_DTAS] = dtas_reg;
		sw[`GIS_BIT_DCAS] = dcas_reg;
	end

	// Registered copy, updated every clock
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			status_word <= `GIS_RST_STATUS;
		else
			status_word <= sw;
	end

	// Read data mux
	wire [31:0] rd_mux =
		hit_st ? {16'h0000, sw} :
		hit_ec ? {16'h0000, error_code} :
		hit_ct ? 32'(xfer_count) :
		hit_cr ? {16'h0000, ctrl_reg} :
		hit_ad ? {16'h0000, addr_reg} : 32'h0000_0000;
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			prdata <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
			prdata <= rd_mux;
	end
endmodule

/* gis_status_word_assertions.sv */
// Purpose: port checks for the status word block
// Assumes: one clock, async active-low reset
// Notes:   bind follows the module
`timescale 1ns/1ps
module gis_status_word_assertions #(
	parameter int CNT_W = 32
) (
	input wire logic               core_clk,
	input wire logic               reset_n,
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pslverr,
	input wire logic               atn_line,
	input wire logic               srq_line,
	input wire logic               ren_line,
	input wire logic               ifc_line,
	input wire logic               cmd_stb,
	input wire logic               xfer_start,
	input wire logic               byte_stb,
	input wire logic               xfer_done,
	input wire logic               ctrl_take,
	input wire gis_pkg::gis_word_t status_word,
	input wire logic [15:0]        error_code,
	input wire logic [CNT_W-1:0]   xfer_count
);
	import gis_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	// Bus clear held two edges, nothing setting flags meanwhile
	sequence s_ifc_held;
		(ifc_line && !ctrl_take && !cmd_stb)[*2];
	endsequence
	// Transfer opened and still running a cycle later
	sequence s_xfer_open;
		xfer_start && !byte_stb ##1 !xfer_done && !byte_stb;
	endsequence
	a_spare_bits_zero:
	assert property (status_word[11:9] == 3'h0) else $error("spare bits");
	a_atn_follows:
	assert property (status_word[4] == $past(atn_line)) else $error("atn");
	a_srq_needs_cic:
	assert property (status_word[12] == ($past(srq_line) && status_word[5]))
		else $error("srq flag");
	a_code_needs_err:
	assert property (error_code != 16'h0 |=> status_word[15])
		else $error("error code without error flag");
	a_ifc_clears:
	assert property (s_ifc_held |=> status_word[5:2] == 4'h0 ||
		status_word[5:2] == 4'h4) else $error("ifc clear");
	a_ren_drop_clears:
	assert property ((!ren_line && !cmd_stb)[*2] |=> status_word[7:6] == 2'h0)
		else $error("ren clear");
	a_count_restart:
	assert property (xfer_start && !byte_stb |=> xfer_count == '0)
		else $error("count restart");
	a_count_step:
	assert property (byte_stb && !xfer_start |=>
		xfer_count == $past(xfer_count) + 1'b1) else $error("count step");
	a_completion_flag_busy:
	assert property (s_xfer_open |=> !status_word[8]) else $error("completion_flag");
	a_end_restart:
	assert property (s_xfer_open |=> !status_word[13]) else $error("end");
	a_slverr_access:
	assert property (pslverr |-> psel && penable) else $error("pslverr");
endmodule
bind gis_status_word gis_status_word_assertions #(.CNT_W(CNT_W)) chk_i (
	.core_clk(core_clk), .reset_n(reset_n), .psel(psel),
	.penable(penable), .pslverr(pslverr), .atn_line(atn_line),
	.srq_line(srq_line), .ren_line(ren_line), .ifc_line(ifc_line),
	.cmd_stb(cmd_stb), .xfer_start(xfer_start), .byte_stb(byte_stb),
	.xfer_done(xfer_done), .ctrl_take(ctrl_take),
	.status_word(status_word), .error_code(error_code),
	.xfer_count(xfer_count));

/* gis_bus_model.sv */
// Purpose: far side of the bus, lines and one-clock strobes
// Assumes: changes land just after a rising edge
// Notes:   idle data lines show the inverse of the last value
`timescale 1ns/1ps
module gis_bus_model (
	input  wire logic  core_clk,
	output logic       atn_line,
	output logic       srq_line,
	output logic       ren_line,
	output logic       ifc_line,
	output logic       cmd_stb,
	output logic [7:0] cmd_data,
	output logic       byte_stb,
	output logic [7:0] byte_data,
	output logic       byte_eoi,
	output logic       xfer_start,
	output logic       xfer_done,
	output logic       ctrl_take,
	output logic       ctrl_pass
);
	// Quiet bus at time zero
	initial begin
		atn_line   = 1'b0;
		srq_line   = 1'b0;
		ren_line   = 1'b0;
		ifc_line   = 1'b0;
		cmd_stb    = 1'b0;
		cmd_data   = 8'h00;
		byte_stb   = 1'b0;
		byte_data  = 8'h00;
		byte_eoi   = 1'b0;
		xfer_start = 1'b0;
		xfer_done  = 1'b0;
		ctrl_take  = 1'b0;
		ctrl_pass  = 1'b0;
	end
	// Levels as {atn, srq, ren, ifc}
	task lines(input logic [3:0] v);
		@(posedge core_clk);
		atn_line <= v[3];
		srq_line <= v[2];
		ren_line <= v[1];
		ifc_line <= v[0];
	endtask
	// One command byte
	task cmd(input logic [7:0] b);
		@(posedge core_clk);
		cmd_stb  <= 1'b1;
		cmd_data <= b;
		@(posedge core_clk);
		cmd_stb  <= 1'b0;
		cmd_data <= ~b;
	endtask
	// One data byte, optionally with end-or-identify
	task put_byte(input logic [7:0] b, input logic e);
		@(posedge core_clk);
		byte_stb  <= 1'b1;
		byte_data <= b;
		byte_eoi  <= e;
		@(posedge core_clk);
		byte_stb  <= 1'b0;
		byte_data <= ~b;
		byte_eoi  <= ~e;
	endtask
	// Start, done, take, pass as bits 0 to 3
	task pulse(input logic [3:0] m);
		@(posedge core_clk);
		xfer_start <= m[0];
		xfer_done  <= m[1];
		ctrl_take  <= m[2];
		ctrl_pass  <= m[3];
		@(posedge core_clk);
		xfer_start <= 1'b0;
		xfer_done  <= 1'b0;
		ctrl_take  <= 1'b0;
		ctrl_pass  <= 1'b0;
	endtask
endmodule

/* gis_status_word_test.sv */
// Purpose: register and flag checks of the status word block
// Assumes: APB slave with zero wait states
// Notes:   status read a few clocks after each event
`timescale 1ns/1ps
`include "gis_defs.svh"
module gis_status_word_test;
	import gis_pkg::*;
	logic        core_clk, reset_n, psel, penable, pwrite, pready, pslverr;
	logic        atn_line, srq_line, ren_line, ifc_line, cmd_stb, byte_stb;
	logic        byte_eoi, eoi_only_mode, err;
	logic        xfer_start, xfer_done, ctrl_take, ctrl_pass;
	logic [7:0]  cmd_data, byte_data;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, xfer_count;
	logic [15:0] error_code;
	gis_word_t   status_word;
	int          errors, n_tests;
	gis_bus_model gis_bus_model_i (.core_clk(core_clk), .atn_line(atn_line),
		.srq_line(srq_line), .ren_line(ren_line), .ifc_line(ifc_line),
		.cmd_stb(cmd_stb), .cmd_data(cmd_data), .byte_stb(byte_stb),
		.byte_data(byte_data), .byte_eoi(byte_eoi), .xfer_start(xfer_start),
		.xfer_done(xfer_done), .ctrl_take(ctrl_take), .ctrl_pass(ctrl_pass));
	gis_status_word #(.CNT_W(32)) gis_status_word_i (.core_clk(core_clk),
		.reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .atn_line(atn_line), .srq_line(srq_line),
		.ren_line(ren_line), .ifc_line(ifc_line), .cmd_stb(cmd_stb),
		.cmd_data(cmd_data), .xfer_start(xfer_start), .byte_stb(byte_stb),
		.byte_data(byte_data), .byte_eoi(byte_eoi), .xfer_done(xfer_done),
		.ctrl_take(ctrl_take), .ctrl_pass(ctrl_pass),
		.status_word(status_word),
		.error_code(error_code), .xfer_count(xfer_count),
		.eoi_only_mode(eoi_only_mode));
	always #25 core_clk = ~core_clk;
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
		n_tests++;
		if (seen !== ex) begin
			errors++;
			$display("BAD %s expected %h seen %h", nm, ex, seen);
		end
	endtask
	// One APB transfer, answer taken at the ready edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1)
			@(posedge core_clk);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	// Status bits under a mask, over the bus and at the port
	task st(input logic [15:0] m, input logic [15:0] v);
		repeat (3) @(posedge core_clk);
		apb(1'b0, `GIS_OFF_STATUS, 32'h0);
		chk("status read", rd & {16'hffff, m}, {16'h0, v});
		@(negedge core_clk);
		chk("status port", {16'h0, status_word & m}, {16'h0, v});
	endtask
	task end_of_test;
		$display("errors %0d checks %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Watchdog
	initial begin
		repeat (20000) @(posedge core_clk);
		errors++;
		end_of_test;
	end
	// Main sequence
	initial begin
		core_clk = 1'b0;
		reset_n  = 1'b0;
		psel     = 1'b0;
		penable  = 1'b0;
		pwrite   = 1'b0;
		paddr    = 12'h000;
		pwdata   = 32'h0000_0000;
		errors = 0;
		n_tests = 0;
		repeat (20) @(posedge core_clk);
		reset_n <= 1'b1;
		st(16'hffff, `GIS_RST_STATUS);
		apb(1'b1, `GIS_OFF_STATUS, 32'hffff_ffff);
		st(16'hffff, `GIS_RST_STATUS);
		apb(1'b1, 12'h018, 32'hffff_ffff);
		apb(1'b0, 12'h018, 32'h0);
		chk("unmapped", {err, rd[30:0]}, 32'h8000_0000);
		apb(1'b1, `GIS_OFF_CALL, 32'h0006_8000);
		st(16'hc000, 16'h8000);
		apb(1'b0, `GIS_OFF_ERRCODE, 32'h0);
		chk("error code", rd, 32'h6);
		apb(1'b1, `GIS_OFF_CALL, 32'h0006_4000);
		st(16'hc000, 16'h4000);
		chk("error code", {16'h0, error_code}, 32'h0);
		apb(1'b1, `GIS_OFF_CALL, 32'h0);
		st(16'hc000, 16'h0);
		apb(1'b1, `GIS_OFF_ADDR, 32'h5);
		gis_bus_model_i.lines(4'b1010);
		gis_bus_model_i.cmd(8'h25);
		st(16'h0054, 16'h0054);
		gis_bus_model_i.cmd(`GIS_CMD_LLO);
		st(16'h0080, 16'h0080);
		gis_bus_model_i.cmd(8'h45);
		st(16'h000c, 16'h0008);
		gis_bus_model_i.cmd(8'h25);
		st(16'h000c, 16'h0004);
		gis_bus_model_i.cmd(`GIS_CMD_GET);
		gis_bus_model_i.cmd(`GIS_CMD_SDC);
		st(16'h0003, 16'h0003);
		apb(1'b1, `GIS_OFF_CALL, 32'h3);
		st(16'h0003, 16'h0);
		gis_bus_model_i.cmd(`GIS_CMD_GTL);
		st(16'h0040, 16'h0);
		gis_bus_model_i.cmd(`GIS_CMD_UNL);
		st(16'h0004, 16'h0);
		gis_bus_model_i.cmd(8'h45);
		gis_bus_model_i.cmd(`GIS_CMD_UNT);
		st(16'h0008, 16'h0);
		gis_bus_model_i.cmd(8'h25);
		gis_bus_model_i.lines(4'b0000);
		st(16'h00d0, 16'h0);
		gis_bus_model_i.pulse(4'h4);
		gis_bus_model_i.lines(4'b0100);
		st(16'h1020, 16'h1020);
		gis_bus_model_i.pulse(4'h8);
		st(16'h1020, 16'h0);
		gis_bus_model_i.pulse(4'h4);
		gis_bus_model_i.lines(4'b0001);
		st(16'h102c, 16'h0);
		gis_bus_model_i.lines(4'b0000);
		apb(1'b1, `GIS_OFF_CTRL, 32'h0a01);
		gis_bus_model_i.pulse(4'h1);
		st(16'h0100, 16'h0);
		gis_bus_model_i.put_byte(8'h41, 1'b0);
		gis_bus_model_i.put_byte(8'h0a, 1'b0);
		gis_bus_model_i.pulse(4'h2);
		st(16'h2100, 16'h2100);
		apb(1'b0, `GIS_OFF_COUNT, 32'h0);
		chk("count", rd, 32'h2);
		apb(1'b1, `GIS_OFF_CTRL, 32'h0a03);
		apb(1'b0, `GIS_OFF_CTRL, 32'h0);
		chk("ctrl", {rd[30:0], eoi_only_mode}, 32'h1407);
		gis_bus_model_i.pulse(4'h1);
		st(16'h2000, 16'h0);
		gis_bus_model_i.put_byte(8'h0a, 1'b0);
		gis_bus_model_i.pulse(4'h2);
		st(16'h2100, 16'h0100);
		gis_bus_model_i.pulse(4'h1);
		gis_bus_model_i.put_byte(8'h33, 1'b1);
		gis_bus_model_i.pulse(4'h2);
		st(16'h2100, 16'h2100);
		// Secondary addressing: primary alone must not address
		apb(1'b1, `GIS_OFF_ADDR, 32'h0305);
		apb(1'b1, `GIS_OFF_CTRL, 32'h0004);
		gis_bus_model_i.lines(4'b1010);
		gis_bus_model_i.cmd(8'h25);
		st(16'h0044, 16'h0);
		gis_bus_model_i.cmd(8'h63);
		st(16'h0044, 16'h0044);
		gis_bus_model_i.cmd(8'h45);
		gis_bus_model_i.cmd(8'h63);
		st(16'h000c, 16'h0008);
		// Another talk address unaddresses the talker
		gis_bus_model_i.cmd(8'h46);
		st(16'h0008, 16'h0);
		// Universal device clear, then cleared by an I/O call end
		gis_bus_model_i.cmd(`GIS_CMD_DCL);
		st(16'h0001, 16'h0001);
		apb(1'b1, `GIS_OFF_CALL, 32'h0000_2000);
		st(16'h0001, 16'h0);
		// Command bytes without attention are ignored
		gis_bus_model_i.lines(4'b0010);
		gis_bus_model_i.cmd(`GIS_CMD_DCL);
		st(16'h0011, 16'h0);
		end_of_test;
	end
endmodule
